// ### hw/vfdc_fifo.sv
// Command byte FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module vfdc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic nrst,
	vfdc_stream_if.snk wr,
	vfdc_stream_if.src rd
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] cnt;
	} vfdc_fifo_state_type;

	vfdc_fifo_state_type s_r;
	vfdc_fifo_state_type s_nxt;
	logic push;
	logic pop;

	assign wr.ready = (s_r.cnt != (AW+1)'(DEPTH));
	assign rd.valid = (s_r.cnt != '0);
	assign rd.data = s_r.mem[s_r.rd_ptr];

	always_comb begin
		s_nxt = s_r;
		push = wr.valid && wr.ready;
		pop = rd.valid && rd.ready;
		if (push) begin
			s_nxt.mem[s_r.wr_ptr] = wr.data;
			s_nxt.wr_ptr = (s_r.wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(s_r.wr_ptr + 1'b1);
		end
		if (pop) begin
			s_nxt.rd_ptr = (s_r.rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(s_r.rd_ptr + 1'b1);
		end
		case ({push, pop})
			2'h2: s_nxt.cnt = (AW+1)'(s_r.cnt + 1'b1);
			2'h1: s_nxt.cnt = (AW+1)'(s_r.cnt - 1'b1);
			default: s_nxt.cnt = s_r.cnt;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule
`default_nettype wire

// ### hw/vfdc_pkg.sv
// Types shared by the serial display controller files
package vfdc_pkg;
	typedef enum logic [2:0] {
		VFDC_INIT_FILL = 3'h1,
		VFDC_INIT_CHECK = 3'h2,
		VFDC_INIT_DONE = 3'h4
	} vfdc_init_type;

	typedef enum logic [2:0] {
		VFDC_EXEC_CMD = 3'h1,
		VFDC_EXEC_LO = 3'h2,
		VFDC_EXEC_HI = 3'h4
	} vfdc_exec_type;
endpackage

// ### hw/vfdc_regs.svh
// Constants of the serial display controller
`ifndef VFDC_REGS_SVH
`define VFDC_REGS_SVH
// How it works
// - Command bits sampled on link clock rising edge
// - Response bits change on link clock falling edge
// - Response line high holds off next byte
// - Self-test and memory fill, line high meanwhile
// - First byte exchanged for self-test result
// - Result 00000001 pass, 01010101 any failure
// - Two straps choose one of four fills
// - Eleven grids, fifteen anodes, fourteen carry segments
// - Grid on 1.37 ms per slot within 16.56 ms scan
// - Scan grids from ten down to zero
// - Grid off, then anodes, then grid on
// - Grid stays off when its anodes blank
// - Core runs at 512 kHz rate
// - Beeper enable high on command, else low
// - Active-high reset input restarts the controller

`define VFDC_CLK_FREQ_KHZ 25000
`define VFDC_CORE_FREQ_KHZ 512
`define VFDC_US_PER_MS 1000
`define VFDC_GRID_ON_US 1370
`define VFDC_SCAN_US 16560
`define VFDC_NUM_GRIDS 11
`define VFDC_NUM_SEGS 14
`define VFDC_NUM_ANODES 15
`define VFDC_BYTE_BITS 8
`define VFDC_FIFO_DEPTH 8
`define VFDC_LAST_GRID 4'ha
`define VFDC_LAST_BIT 3'h7
`define VFDC_ST_PASS 8'h01
`define VFDC_ST_FAIL 8'h55
`define VFDC_SEG_ALL_ON 14'h3fff
`define VFDC_SEG_ALL_OFF 14'h0000
`define VFDC_PAT_A 14'h2aaa
`define VFDC_PAT_B 14'h1555
`define VFDC_STRAP_OFF 2'h3
`define VFDC_STRAP_ON 2'h2
`define VFDC_STRAP_PAT1 2'h1
`define VFDC_OP_BEEP_ON 4'h1
`define VFDC_OP_BEEP_OFF 4'h2
`define VFDC_OP_GRID_SEL 4'h3
`define VFDC_OP_CLEAR 4'h4
`endif

// ### hw/vfdc_stream_if.sv
// Valid/ready byte stream between controller modules
`timescale 1ns/100ps
`default_nettype none
interface vfdc_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// ### hw/vfdc_top.sv
// Serial command link, self-test, display memory and grid scan
`timescale 1ns/100ps
`default_nettype none
`include "vfdc_regs.svh"
module vfdc_top #(
	parameter int CORE_DIV = `VFDC_CLK_FREQ_KHZ / `VFDC_CORE_FREQ_KHZ,
	parameter int GRID_ON_TICKS = `VFDC_GRID_ON_US * `VFDC_CORE_FREQ_KHZ / `VFDC_US_PER_MS,
	parameter int SLOT_TICKS = `VFDC_SCAN_US * `VFDC_CORE_FREQ_KHZ / (`VFDC_US_PER_MS * `VFDC_NUM_GRIDS),
	parameter int FIFO_DEPTH = `VFDC_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic display_rst,
	input wire logic serial_link_clk,
	input wire logic serial_cmd_in,
	output logic serial_resp_out,
	input wire logic test_select_n,
	input wire logic lamp_select_n,
	output logic [`VFDC_NUM_GRIDS-1:0] grid_out,
	output logic [`VFDC_NUM_ANODES-1:0] anode_out,
	output logic beep_en
);
	localparam int DIV_W = $clog2(CORE_DIV + 1);
	localparam int SLOT_W = $clog2(SLOT_TICKS + 1);
	// Grid enable point leaves the start of the slot blank
	localparam int GRID_EN_AT = SLOT_TICKS - GRID_ON_TICKS - 1;

	typedef struct packed {
		logic sclk_m;
		logic sclk_s;
		logic sclk_d;
		logic cmd_m;
		logic cmd_s;
		logic test_m;
		logic test_s;
		logic lamp_m;
		logic lamp_s;
		logic rst_m;
		logic rst_s;
		logic [DIV_W-1:0] div_cnt;
		logic core_tick;
		logic [`VFDC_BYTE_BITS-1:0] rx_sh;
		logic [2:0] bit_cnt;
		logic [`VFDC_BYTE_BITS-1:0] tx_sh;
		logic push;
		logic hold;
		logic resp;
		vfdc_pkg::vfdc_init_type init;
		logic [3:0] idx;
		logic fail;
		vfdc_pkg::vfdc_exec_type exec;
		logic [3:0] sel;
		logic [`VFDC_BYTE_BITS-1:0] lo;
		logic beep;
		logic [`VFDC_NUM_GRIDS-1:0][`VFDC_NUM_SEGS-1:0] mem;
		logic [3:0] grid_idx;
		logic [SLOT_W-1:0] slot_cnt;
		logic [`VFDC_NUM_GRIDS-1:0] grid;
		logic [`VFDC_NUM_ANODES-1:0] anode;
	} vfdc_state_type;

	// Link clock idles high, so its synchroniser starts high: no false edge after reset
	localparam vfdc_state_type RST_STATE = '{
		sclk_m: 1'h1,
		sclk_s: 1'h1,
		sclk_d: 1'h1,
		init: vfdc_pkg::VFDC_INIT_FILL,
		exec: vfdc_pkg::VFDC_EXEC_CMD,
		grid_idx: `VFDC_LAST_GRID,
		resp: 1'h1,
		default: '0
	};

	vfdc_state_type s_r;
	vfdc_state_type s_nxt;
	logic sclk_rise;
	logic sclk_fall;
	logic pop;
	logic [`VFDC_NUM_SEGS-1:0] fill_val;

	vfdc_stream_if #(.WIDTH(`VFDC_BYTE_BITS)) push_if ();
	vfdc_stream_if #(.WIDTH(`VFDC_BYTE_BITS)) pop_if ();

	vfdc_fifo #(
		.WIDTH(`VFDC_BYTE_BITS),
		.DEPTH(FIFO_DEPTH)
	) cmd_fifo (
		.clock(clock),
		.nrst(nrst),
		.wr(push_if.snk),
		.rd(pop_if.src)
	);

	function automatic logic [`VFDC_NUM_SEGS-1:0] init_pattern(input logic [3:0] g, input logic [1:0] code);
		case (code)
			`VFDC_STRAP_OFF: init_pattern = `VFDC_SEG_ALL_OFF;
			`VFDC_STRAP_ON: init_pattern = `VFDC_SEG_ALL_ON;
			`VFDC_STRAP_PAT1: init_pattern = g[0] ? `VFDC_PAT_B : `VFDC_PAT_A;
			default: init_pattern = g[0] ? `VFDC_PAT_A : `VFDC_PAT_B;
		endcase
	endfunction

	assign push_if.valid = s_r.push;
	assign push_if.data = s_r.rx_sh;
	// Executor is paced by the core rate, so a byte waits in the FIFO
	assign pop = s_r.core_tick && pop_if.valid && (s_r.init == vfdc_pkg::VFDC_INIT_DONE);
	assign pop_if.ready = pop;

	assign serial_resp_out = s_r.resp;
	assign grid_out = s_r.grid;
	assign anode_out = s_r.anode;
	assign beep_en = s_r.beep;

	always_comb begin
		s_nxt = s_r;
		s_nxt.push = 1'h0;
		s_nxt.core_tick = 1'h0;

		s_nxt.sclk_m = serial_link_clk;
		s_nxt.sclk_s = s_r.sclk_m;
		s_nxt.sclk_d = s_r.sclk_s;
		s_nxt.cmd_m = serial_cmd_in;
		s_nxt.cmd_s = s_r.cmd_m;
		s_nxt.test_m = test_select_n;
		s_nxt.test_s = s_r.test_m;
		s_nxt.lamp_m = lamp_select_n;
		s_nxt.lamp_s = s_r.lamp_m;
		s_nxt.rst_m = display_rst;
		s_nxt.rst_s = s_r.rst_m;
		sclk_rise = s_r.sclk_s && !s_r.sclk_d;
		sclk_fall = !s_r.sclk_s && s_r.sclk_d;

		if (s_r.div_cnt == DIV_W'(CORE_DIV - 1)) begin
			s_nxt.div_cnt = '0;
			s_nxt.core_tick = 1'h1;
		end else begin
			s_nxt.div_cnt = DIV_W'(s_r.div_cnt + 1'b1);
		end

		// Power-up fill from straps, then read back as the self-test
		fill_val = init_pattern(s_r.idx, {s_r.test_s, s_r.lamp_s});
		case (s_r.init)
			vfdc_pkg::VFDC_INIT_FILL: begin
				if (s_r.core_tick) begin
					s_nxt.mem[s_r.idx] = fill_val;
					if (s_r.idx == `VFDC_LAST_GRID) begin
						s_nxt.idx = '0;
						s_nxt.init = vfdc_pkg::VFDC_INIT_CHECK;
					end else begin
						s_nxt.idx = 4'(s_r.idx + 1'b1);
					end
				end
			end
			vfdc_pkg::VFDC_INIT_CHECK: begin
				if (s_r.core_tick) begin
					if (s_r.mem[s_r.idx] != fill_val) begin
						s_nxt.fail = 1'h1;
					end
					if (s_r.idx == `VFDC_LAST_GRID) begin
						s_nxt.init = vfdc_pkg::VFDC_INIT_DONE;
						s_nxt.tx_sh = s_nxt.fail ? `VFDC_ST_FAIL : `VFDC_ST_PASS;
					end else begin
						s_nxt.idx = 4'(s_r.idx + 1'b1);
					end
				end
			end
			vfdc_pkg::VFDC_INIT_DONE: begin
			end
			default: s_nxt.init = vfdc_pkg::VFDC_INIT_FILL;
		endcase

		if (pop) begin
			// Next exchange echoes the byte just handled
			s_nxt.tx_sh = pop_if.data;
			s_nxt.hold = 1'h0;
			case (s_r.exec)
				vfdc_pkg::VFDC_EXEC_CMD: begin
					case (pop_if.data[7:4])
						`VFDC_OP_BEEP_ON: s_nxt.beep = 1'h1;
						`VFDC_OP_BEEP_OFF: s_nxt.beep = 1'h0;
						`VFDC_OP_GRID_SEL: begin
							s_nxt.sel = pop_if.data[3:0];
							s_nxt.exec = vfdc_pkg::VFDC_EXEC_LO;
						end
						`VFDC_OP_CLEAR: s_nxt.mem = '0;
						default: s_nxt.exec = vfdc_pkg::VFDC_EXEC_CMD;
					endcase
				end
				vfdc_pkg::VFDC_EXEC_LO: begin
					s_nxt.lo = pop_if.data;
					s_nxt.exec = vfdc_pkg::VFDC_EXEC_HI;
				end
				vfdc_pkg::VFDC_EXEC_HI: begin
					// Out-of-range grid select writes nothing
					if (s_r.sel <= `VFDC_LAST_GRID) begin
						s_nxt.mem[s_r.sel] = {pop_if.data[5:0], s_r.lo};
					end
					s_nxt.exec = vfdc_pkg::VFDC_EXEC_CMD;
				end
				default: s_nxt.exec = vfdc_pkg::VFDC_EXEC_CMD;
			endcase
		end

		// Receive: MSB first, eight rising edges per byte
		if (sclk_rise && s_r.init == vfdc_pkg::VFDC_INIT_DONE) begin
			s_nxt.rx_sh = {s_r.rx_sh[6:0], s_r.cmd_s};
			s_nxt.bit_cnt = 3'(s_r.bit_cnt + 1'b1);
			if (s_r.bit_cnt == `VFDC_LAST_BIT) begin
				s_nxt.rx_sh = {s_r.rx_sh[6:0], s_r.cmd_s};
				s_nxt.push = 1'h1;
				// Set after the clear above, so a new byte is never lost
				s_nxt.hold = 1'h1;
			end
		end

		// Transmit: next bit appears after each falling edge
		if (sclk_fall && !s_r.hold && s_r.init == vfdc_pkg::VFDC_INIT_DONE) begin
			s_nxt.resp = s_r.tx_sh[7];
			s_nxt.tx_sh = {s_r.tx_sh[6:0], 1'h0};
		end

		// Grid scan, one slot per grid, highest grid first
		if (s_r.core_tick) begin
			if (s_r.slot_cnt == SLOT_W'(SLOT_TICKS - 1)) begin
				s_nxt.slot_cnt = '0;
				s_nxt.grid = '0;
				s_nxt.grid_idx = (s_r.grid_idx == 4'h0) ? `VFDC_LAST_GRID : 4'(s_r.grid_idx - 1'b1);
			end else begin
				s_nxt.slot_cnt = SLOT_W'(s_r.slot_cnt + 1'b1);
			end
			if (s_r.slot_cnt == '0) begin
				s_nxt.anode = {1'h0, s_r.mem[s_r.grid_idx]};
			end
			// Enable well after anodes settle; blank grid stays dark
			if (s_r.slot_cnt == SLOT_W'(GRID_EN_AT) && s_r.anode != '0) begin
				s_nxt.grid = '0;
				s_nxt.grid[s_r.grid_idx] = 1'h1;
			end
		end

		// Display reset restarts self-test and the link
		if (s_r.rst_s) begin
			s_nxt.init = vfdc_pkg::VFDC_INIT_FILL;
			s_nxt.exec = vfdc_pkg::VFDC_EXEC_CMD;
			s_nxt.idx = '0;
			s_nxt.fail = 1'h0;
			s_nxt.hold = 1'h0;
			s_nxt.bit_cnt = '0;
			s_nxt.push = 1'h0;
			s_nxt.beep = 1'h0;
		end

		// Line high while busy; drops low once ready for the next byte
		if (s_nxt.hold || s_nxt.init != vfdc_pkg::VFDC_INIT_DONE) begin
			s_nxt.resp = 1'h1;
		end else if (s_r.hold || s_r.init != vfdc_pkg::VFDC_INIT_DONE) begin
			s_nxt.resp = 1'h0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_r <= RST_STATE;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Random and directed tests of the display controller
`timescale 1ns/100ps
`default_nettype none
`include "vfdc_regs.svh"
module tb_top;
	localparam int DIV = 2;
	localparam int SLOT = 12;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic display_rst = 1'b0;
	logic test_select_n = 1'b1;
	logic lamp_select_n = 1'b0;
	logic serial_link_clk, serial_cmd_in, serial_resp_out, beep_en, host_err;
	logic [`VFDC_NUM_GRIDS-1:0] grid_out;
	logic [`VFDC_NUM_ANODES-1:0] anode_out;
	logic [7:0] rx, prev;
	logic [13:0] seg [11];
	logic [13:0] pat [11];
	logic [10:0] seen;
	int bad_count = 0;
	int total_checks = 0;
	int order_err;
	always #20 clock = ~clock;
	vfdc_top #(.CORE_DIV(DIV), .GRID_ON_TICKS(8), .SLOT_TICKS(SLOT), .FIFO_DEPTH(8)) i_vfdc_top (
		.clock(clock), .nrst(nrst), .display_rst(display_rst), .serial_link_clk(serial_link_clk),
		.serial_cmd_in(serial_cmd_in), .serial_resp_out(serial_resp_out), .test_select_n(test_select_n),
		.lamp_select_n(lamp_select_n), .grid_out(grid_out), .anode_out(anode_out), .beep_en(beep_en));
	vfdc_host_model i_vfdc_host_model (.clock(clock), .serial_link_clk(serial_link_clk),
		.serial_cmd_in(serial_cmd_in), .serial_resp_out(serial_resp_out), .host_err(host_err));
	function automatic int next_grid(int g);
		return g == 0 ? 10 : g - 1;
	endfunction
	task automatic check(string name, logic [15:0] got, logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic scan;
		int last;
		last = -1;
		seen = '0;
		order_err = 0;
		repeat (11 * SLOT * DIV + 40) begin
			@(posedge clock) #1;
			for (int g = 0; g < 11; g++) begin
				if (grid_out[g] === 1'b1 && !seen[g]) begin
					seen[g] = 1'b1;
					seg[g] = anode_out[13:0];
					if (last >= 0 && g != next_grid(last)) order_err++;
					last = g;
				end
			end
		end
	endtask
	initial begin
		logic [7:0] b;
		logic [13:0] d;
		b = 8'($urandom(31));
		repeat (3) @(posedge clock);
		#1 nrst = 1'b1;
		prev = 8'h07;
		i_vfdc_host_model.xfer(prev, rx);
		check("self test", rx, `VFDC_ST_PASS);
		for (int k = 0; k < 8; k++) begin
			b = {4'h5 + 4'($urandom % 11), 4'($urandom)};
			if (k == 0) b = {`VFDC_OP_BEEP_ON, 4'h9};
			if (k == 1) b = {`VFDC_OP_BEEP_OFF, 4'h9};
			i_vfdc_host_model.xfer(b, rx);
			check("echo", rx, prev);
			prev = b;
			repeat (8) @(posedge clock);
			#1;
			check("beep", beep_en, k == 0);
		end
		for (int c = 3; c >= 0; c--) begin
			{test_select_n, lamp_select_n} = 2'(c);
			display_rst = 1'b1;
			repeat (8) @(posedge clock);
			#1;
			check("busy in reset", serial_resp_out, 1'b1);
			display_rst = 1'b0;
			i_vfdc_host_model.xfer(8'h00, rx);
			check("self test", rx, `VFDC_ST_PASS);
			scan;
			check("lit grids", seen, c == 3 ? 11'h000 : 11'h7ff);
			check("scan order", 16'(order_err), 16'h0000);
			for (int g = 0; g < 11; g++) begin
				if (c == 2) check("all on", seg[g], `VFDC_SEG_ALL_ON);
				if (c == 1) pat[g] = seg[g];
				if (c == 1) check("pattern one", seg[g], (g % 2) ? `VFDC_PAT_B : `VFDC_PAT_A);
				if (c == 0) check("patterns", seg[g] ^ pat[g], 14'h3fff);
				if (c == 0 && g > 0) check("parity", pat[g] ^ pat[g - 1], 14'h3fff);
			end
		end
		d = {6'($urandom) | 6'h01, 8'($urandom)};
		i_vfdc_host_model.xfer({`VFDC_OP_CLEAR, 4'h0}, rx);
		i_vfdc_host_model.xfer({`VFDC_OP_GRID_SEL, 4'h5}, rx);
		i_vfdc_host_model.xfer(d[7:0], rx);
		i_vfdc_host_model.xfer({2'h0, d[13:8]}, rx);
		// Grid select past the last grid must leave memory alone
		i_vfdc_host_model.xfer({`VFDC_OP_GRID_SEL, 4'hb}, rx);
		i_vfdc_host_model.xfer(8'hff, rx);
		i_vfdc_host_model.xfer(8'h3f, rx);
		check("echo", rx, 8'hff);
		repeat (4) @(posedge clock);
		scan;
		check("only grid", seen, 11'h020);
		check("grid data", seg[5], d);
		check("host wait", host_err, 1'b0);
		final_report;
	end
	initial begin
		#1600000;
		bad_count++;
		final_report;
	end
endmodule
`default_nettype wire

// ### test/vfdc_host_model.sv
// Host end of the three-wire command link
`timescale 1ns/100ps
`default_nettype none
module vfdc_host_model #(
	parameter int HALF = 8
) (
	input wire logic clock,
	output logic serial_link_clk,
	output logic serial_cmd_in,
	input wire logic serial_resp_out,
	output logic host_err
);
	initial begin
		serial_link_clk = 1'b1;
		serial_cmd_in = 1'b1;
		host_err = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		int n;
		n = 0;
		while (serial_resp_out !== 1'b0 && n < 5000) begin
			@(posedge clock);
			n++;
		end
		host_err = host_err | (n >= 5000);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clock) #1;
			serial_link_clk = 1'b0;
			serial_cmd_in = tx[i];
			repeat (HALF) @(posedge clock);
			#1;
			rx[i] = serial_resp_out;
			serial_link_clk = 1'b1;
			repeat (HALF) @(posedge clock);
		end
		// Stale data would hide a missed sample
		#1 serial_cmd_in = ~tx[0];
	endtask
endmodule
`default_nettype wire

// ### test/vfdc_monitor.sv
// Port checker for the serial display controller
`timescale 1ns/100ps
`default_nettype none
`include "vfdc_regs.svh"
module vfdc_monitor #(
	parameter int CORE_DIV = 2,
	parameter int GRID_ON_TICKS = 8
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic display_rst,
	input wire logic serial_link_clk,
	input wire logic serial_cmd_in,
	input wire logic serial_resp_out,
	input wire logic test_select_n,
	input wire logic lamp_select_n,
	input wire logic [`VFDC_NUM_GRIDS-1:0] grid_out,
	input wire logic [`VFDC_NUM_ANODES-1:0] anode_out,
	input wire logic beep_en
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	logic [15:0] on_cnt_r;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			on_cnt_r <= 16'h0000;
		end else begin
			on_cnt_r <= |grid_out ? on_cnt_r + 16'h0001 : 16'h0000;
		end
	end
	sequence s_init_hold;
		serial_resp_out [*8];
	endsequence
	sequence s_gap;
		!(|grid_out) [*2];
	endsequence
	chk_grid_single: assert property ($onehot0(grid_out)) else $error("two grids on");
	chk_spare_anode: assert property (anode_out[14] == 1'b0) else $error("spare anode");
	chk_grid_lit: assert property (|grid_out |-> |anode_out[13:0]) else $error("blank grid on");
	chk_anode_hold: assert property (|grid_out |-> $stable(anode_out)) else $error("anodes moved");
	chk_grid_gap: assert property ($fell(|grid_out) |=> s_gap) else $error("no gap");
	chk_grid_span: assert property ($fell(|grid_out) |-> on_cnt_r >= (GRID_ON_TICKS - 1) * CORE_DIV
		&& on_cnt_r <= (GRID_ON_TICKS + 1) * CORE_DIV) else $error("grid time");
	chk_init_busy: assert property ($rose(nrst) |-> s_init_hold) else $error("init not busy");
	chk_rst_quiet: assert property (display_rst [*6] |-> serial_resp_out && !beep_en)
		else $error("reset ignored");
endmodule
bind vfdc_top vfdc_monitor #(.CORE_DIV(CORE_DIV), .GRID_ON_TICKS(GRID_ON_TICKS)) i_vfdc_monitor (
	.clock(clock), .nrst(nrst), .display_rst(display_rst), .serial_link_clk(serial_link_clk),
	.serial_cmd_in(serial_cmd_in), .serial_resp_out(serial_resp_out), .test_select_n(test_select_n),
	.lamp_select_n(lamp_select_n), .grid_out(grid_out), .anode_out(anode_out), .beep_en(beep_en));
`default_nettype wire
